// [design/fdb_pkg.sv]
package fdb_pkg;

  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_SELECT = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_LEN = 4'h5;

  localparam int BUF_DEPTH = 8;
  localparam int IDX_W = 3;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [IDX_W-1:0] IDX_RESET = 3'h0;
  localparam logic [IDX_W-1:0] IDX_STEP = 3'h1;
  localparam logic [3:0] LEN_MAX = 4'h8;

  localparam int SEL_AINC_BIT = 3;
  localparam int CTRL_UART_BIT = 0;

  localparam int ST_RXOK = 0;
  localparam int ST_TXOK = 1;
  localparam int ST_ERR = 2;
  localparam int ST_W = 3;

  typedef enum logic [1:0] {
    FDB_IDLE = 2'b00,
    FDB_ACK = 2'b01
  } fdb_bus_type;

endpackage

// [design/fdb_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module fdb_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_a_i,
  input wire logic [AW-1:0] addr_a_i,
  input wire logic [DW-1:0] wdata_a_i,
  output logic [DW-1:0] rdata_a_o,
  input wire logic wr_b_i,
  input wire logic [AW-1:0] addr_b_i,
  input wire logic [DW-1:0] wdata_b_i,
  output logic [DW-1:0] rdata_b_o
);
  logic [DW-1:0] mem [DEPTH];

  // Port A is software, port B the frame engine; software wins a same-slot clash.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      if (wr_b_i) begin
        mem[addr_b_i] <= wdata_b_i;
      end
      if (wr_a_i) begin
        mem[addr_a_i] <= wdata_a_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_a_o <= '0;
      rdata_b_o <= '0;
    end else begin
      rdata_a_o <= mem[addr_a_i];
      rdata_b_o <= mem[addr_b_i];
    end
  end
endmodule
`default_nettype wire

// [design/fdb_port.sv]
// Notes on behaviour
// - In LIN mode a 3-bit buffer index selects which slot the data port reaches.
// - In UART mode the buffer index has no effect on data port accesses.
// - In LIN mode the 8-bit data port reads or writes the indexed buffer slot.
// - In UART mode the data port is one plain data register with no buffer behind it.
// - A data port write is outgoing data handed to the frame engine for sending.
// - A data port read returns received data, and the port resets to zero.
// - In LIN mode the index advances after each port access unless auto increment is disabled.
// - In UART mode reading the data port clears the receive-complete and error flags.
// - In UART mode writing the data port clears the transmit-complete flag.
// - In LIN mode transmit and receive byte counts are clamped to at most 8.
`timescale 1ns/1ps
`default_nettype none
module fdb_port
  import fdb_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [ADDR_W-1:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic ERR_O,
  output logic INT_O,
  output logic UART_MODE_O,
  output logic [3:0] TX_LEN_O,
  output logic [3:0] RX_LEN_O,
  output logic TX_DATA_VALID_O,
  output logic [7:0] TX_DATA_O,
  input wire logic ENG_WR_I,
  input wire logic [IDX_W-1:0] ENG_IDX_I,
  input wire logic [7:0] ENG_DATA_I,
  output logic [7:0] ENG_DATA_O,
  input wire logic RX_DONE_I,
  input wire logic TX_DONE_I,
  input wire logic ERR_EVT_I
);
  fdb_bus_type state;
  logic req;
  logic hit;
  logic wr_data;
  logic rd_data;
  logic [IDX_W-1:0] buffer_index;
  logic auto_increment_disable;
  logic uart_mode;
  logic [7:0] uart_data;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [3:0] tx_byte_count;
  logic [3:0] rx_byte_count;
  logic [7:0] buf_rdata;
  logic [7:0] port_data_byte;
  logic [31:0] next_dat;
  logic [ST_W-1:0] next_status;
  logic [ST_W-1:0] w1c;
  logic lane0;

  assign req = CYC_I && STB_I && (state == FDB_IDLE);
  assign lane0 = SEL_I[0];
  assign hit = (ADR_I == ADDR_DATA) || (ADR_I == ADDR_SELECT) || (ADR_I == ADDR_CTRL)
    || (ADR_I == ADDR_STATUS) || (ADR_I == ADDR_MASK) || (ADR_I == ADDR_LEN);
  assign wr_data = req && WE_I && lane0 && (ADR_I == ADDR_DATA);
  assign rd_data = req && !WE_I && (ADR_I == ADDR_DATA);

  fdb_mem #(
    .DEPTH(DEPTH),
    .AW(IDX_W),
    .DW(8)
  ) u_mem (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .wr_a_i(wr_data && !uart_mode),
    .addr_a_i(buffer_index),
    .wdata_a_i(DAT_I[7:0]),
    .rdata_a_o(buf_rdata),
    .wr_b_i(ENG_WR_I && !uart_mode),
    .addr_b_i(ENG_IDX_I),
    .wdata_b_i(ENG_DATA_I),
    .rdata_b_o(ENG_DATA_O)
  );

  // The read data register tracks the selected slot so the answer is ready at ack.
  always_comb begin
    if (uart_mode) begin
      port_data_byte = uart_data;
    end else begin
      port_data_byte = buf_rdata;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= FDB_IDLE;
    end else begin
      case (state)
        FDB_IDLE: begin
          if (CYC_I && STB_I) begin
            state <= FDB_ACK;
          end
        end
        FDB_ACK: state <= FDB_IDLE;
        default: state <= FDB_IDLE;
      endcase
    end
  end

  assign ACK_O = (state == FDB_ACK) && hit && CYC_I && STB_I;
  assign ERR_O = (state == FDB_ACK) && !hit && CYC_I && STB_I;

  always_comb begin
    next_dat = 32'h0000_0000;
    case (ADR_I)
      ADDR_DATA: next_dat[7:0] = port_data_byte;
      ADDR_SELECT: begin
        next_dat[IDX_W-1:0] = buffer_index;
        next_dat[SEL_AINC_BIT] = auto_increment_disable;
      end
      ADDR_CTRL: next_dat[CTRL_UART_BIT] = uart_mode;
      ADDR_STATUS: next_dat[ST_W-1:0] = status;
      ADDR_MASK: next_dat[ST_W-1:0] = mask;
      ADDR_LEN: next_dat[7:0] = {tx_byte_count, rx_byte_count};
      default: next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DAT_O <= 32'h0000_0000;
    end else if (req && !WE_I) begin
      DAT_O <= next_dat;
    end
  end

  // Index register: software writes it; port accesses advance it in LIN mode.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      buffer_index <= IDX_RESET;
      auto_increment_disable <= 1'b0;
    end else if (req && WE_I && lane0 && ADR_I == ADDR_SELECT) begin
      buffer_index <= DAT_I[IDX_W-1:0];
      auto_increment_disable <= DAT_I[SEL_AINC_BIT];
    end else if ((wr_data || rd_data) && !uart_mode && !auto_increment_disable) begin
      buffer_index <= buffer_index + IDX_STEP;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      uart_mode <= 1'b0;
      mask <= '0;
      tx_byte_count <= 4'h0;
      rx_byte_count <= 4'h0;
    end else if (req && WE_I && lane0) begin
      if (ADR_I == ADDR_CTRL) begin
        uart_mode <= DAT_I[CTRL_UART_BIT];
      end
      if (ADR_I == ADDR_MASK) begin
        mask <= DAT_I[ST_W-1:0];
      end
      if (ADR_I == ADDR_LEN) begin
        tx_byte_count <= (DAT_I[7:4] > LEN_MAX) ? LEN_MAX : DAT_I[7:4];
        rx_byte_count <= (DAT_I[3:0] > LEN_MAX) ? LEN_MAX : DAT_I[3:0];
      end
    end
  end

  // UART data register: software writes outgoing, engine loads received.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      uart_data <= DATA_RESET;
    end else if (wr_data && uart_mode) begin
      uart_data <= DAT_I[7:0];
    end else if (ENG_WR_I && uart_mode) begin
      uart_data <= ENG_DATA_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      TX_DATA_VALID_O <= 1'b0;
      TX_DATA_O <= DATA_RESET;
    end else begin
      TX_DATA_VALID_O <= wr_data;
      if (wr_data) begin
        TX_DATA_O <= DAT_I[7:0];
      end
    end
  end

  always_comb begin
    w1c = '0;
    if (req && WE_I && lane0 && ADR_I == ADDR_STATUS) begin
      w1c = DAT_I[ST_W-1:0];
    end
    if (rd_data && uart_mode) begin
      w1c[ST_RXOK] = 1'b1;
      w1c[ST_ERR] = 1'b1;
    end
    if (wr_data && uart_mode) begin
      w1c[ST_TXOK] = 1'b1;
    end
    next_status = (status & ~w1c) | {ERR_EVT_I, TX_DONE_I, RX_DONE_I};
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  assign INT_O = |(status & mask);
  assign UART_MODE_O = uart_mode;
  assign TX_LEN_O = tx_byte_count;
  assign RX_LEN_O = rx_byte_count;
endmodule
`default_nettype wire

// [sim/fdb_eng.sv]
`timescale 1ns/1ps
`default_nettype none
module fdb_eng (
  input wire logic clk_i,
  input wire logic [7:0] q_i,
  output logic wr_o,
  output logic [2:0] idx_o,
  output logic [7:0] data_o,
  output logic [2:0] evt_o
);
  initial begin
    wr_o = 1'b0;
    idx_o = 3'h0;
    data_o = 8'h00;
    evt_o = 3'h0;
  end
  // Released data is inverted so a stale byte is never mistaken for a fresh one.
  task automatic put(input logic [2:0] i, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    idx_o <= i;
    data_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    data_o <= ~d;
  endtask
  task automatic peek(input logic [2:0] i, output logic [7:0] d);
    @(posedge clk_i);
    idx_o <= i;
    @(posedge clk_i);
    @(negedge clk_i);
    d = q_i;
  endtask
  task automatic evt(input logic [2:0] e);
    @(posedge clk_i);
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= 3'h0;
  endtask
endmodule
`default_nettype wire

// [sim/fdb_port_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module fdb_port_chk
  import fdb_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [ADDR_W-1:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic ERR_O,
  input wire logic UART_MODE_O,
  input wire logic [3:0] TX_LEN_O,
  input wire logic [3:0] RX_LEN_O,
  input wire logic TX_DATA_VALID_O,
  input wire logic [7:0] TX_DATA_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire logic tk = CYC_I && STB_I && !ACK_O && !ERR_O;
  wire logic tw = tk && WE_I && SEL_I[0];
  wire logic [7:0] wd = DAT_I[7:0];
  wire logic wm = DAT_I[CTRL_UART_BIT];
  wire logic [3:0] rc = DAT_I[3:0] > 4'h8 ? 4'h8 : DAT_I[3:0];
  wire logic [3:0] tc = DAT_I[7:4] > 4'h8 ? 4'h8 : DAT_I[7:4];
  property p_ack; tk && ADR_I <= ADDR_LEN |=> ACK_O && !ERR_O; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_err; tk && ADR_I > ADDR_LEN |=> ERR_O && !ACK_O; endproperty
  a_err: assert property (p_err) else $error("no err");
  property p_one; ACK_O |=> !ACK_O; endproperty
  a_one: assert property (p_one) else $error("long ack");
  property p_hi; ACK_O && !WE_I |-> DAT_O[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper bits");
  property p_tx; tw && ADR_I == ADDR_DATA |=> TX_DATA_VALID_O && TX_DATA_O == $past(wd); endproperty
  a_tx: assert property (p_tx) else $error("tx byte");
  property p_txp; TX_DATA_VALID_O |=> !TX_DATA_VALID_O; endproperty
  a_txp: assert property (p_txp) else $error("tx pulse");
  property p_len; tw && ADR_I == ADDR_LEN |=> RX_LEN_O == $past(rc) && TX_LEN_O == $past(tc);
  endproperty
  a_len: assert property (p_len) else $error("len clamp");
  property p_mode; tw && ADR_I == ADDR_CTRL |=> UART_MODE_O == $past(wm); endproperty
  a_mode: assert property (p_mode) else $error("mode");
endmodule
bind fdb_port fdb_port_chk chk (
  .CLK_I(CLK_I),
  .RST_N_I(RST_N_I),
  .CYC_I(CYC_I),
  .STB_I(STB_I),
  .WE_I(WE_I),
  .ADR_I(ADR_I),
  .SEL_I(SEL_I),
  .DAT_I(DAT_I),
  .DAT_O(DAT_O),
  .ACK_O(ACK_O),
  .ERR_O(ERR_O),
  .UART_MODE_O(UART_MODE_O),
  .TX_LEN_O(TX_LEN_O),
  .RX_LEN_O(RX_LEN_O),
  .TX_DATA_VALID_O(TX_DATA_VALID_O),
  .TX_DATA_O(TX_DATA_O)
);
`default_nettype wire

// [sim/fdb_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module fdb_port_tb;
  import fdb_pkg::*;
  logic CLK_I, RST_N_I, CYC_I, STB_I, WE_I, ACK_O, ERR_O, INT_O, UART_MODE_O;
  logic TX_DATA_VALID_O, ENG_WR_I, e_seen;
  logic [3:0] ADR_I, SEL_I, TX_LEN_O, RX_LEN_O;
  logic [31:0] DAT_I, DAT_O, q;
  logic [7:0] TX_DATA_O, ENG_DATA_I, ENG_DATA_O, b;
  logic [7:0] mem [8];
  logic [2:0] ENG_IDX_I, ev;
  wire logic RX_DONE_I = ev[0];
  wire logic TX_DONE_I = ev[1];
  wire logic ERR_EVT_I = ev[2];
  int seed = 89724;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc_n = 0;
  fdb_port uut (
    .CLK_I(CLK_I),
    .RST_N_I(RST_N_I),
    .CYC_I(CYC_I),
    .STB_I(STB_I),
    .WE_I(WE_I),
    .ADR_I(ADR_I),
    .SEL_I(SEL_I),
    .DAT_I(DAT_I),
    .DAT_O(DAT_O),
    .ACK_O(ACK_O),
    .ERR_O(ERR_O),
    .INT_O(INT_O),
    .UART_MODE_O(UART_MODE_O),
    .TX_LEN_O(TX_LEN_O),
    .RX_LEN_O(RX_LEN_O),
    .TX_DATA_VALID_O(TX_DATA_VALID_O),
    .TX_DATA_O(TX_DATA_O),
    .ENG_WR_I(ENG_WR_I),
    .ENG_IDX_I(ENG_IDX_I),
    .ENG_DATA_I(ENG_DATA_I),
    .ENG_DATA_O(ENG_DATA_O),
    .RX_DONE_I(RX_DONE_I),
    .TX_DONE_I(TX_DONE_I),
    .ERR_EVT_I(ERR_EVT_I)
  );
  fdb_eng eng (.clk_i(CLK_I), .q_i(ENG_DATA_O), .wr_o(ENG_WR_I), .idx_o(ENG_IDX_I),
    .data_o(ENG_DATA_I), .evt_o(ev));
  initial begin
    CLK_I = 1'b0;
    forever #2 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  function automatic logic [3:0] clamp(input logic [3:0] v);
    return v > 4'h8 ? 4'h8 : v;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= w;
    ADR_I <= a;
    DAT_I <= d;
    do begin
      @(posedge CLK_I);
    end while (ACK_O !== 1'b1 && ERR_O !== 1'b1);
    q = DAT_O;
    e_seen = ERR_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic ci(input logic e);
    @(negedge CLK_I);
    chk({31'h0, INT_O}, {31'h0, e});
  endtask
  task end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    RST_N_I = 1'b0;
    CYC_I = 1'b0;
    STB_I = 1'b0;
    WE_I = 1'b0;
    ADR_I = 4'h0;
    SEL_I = 4'hF;
    DAT_I = 32'h0;
    repeat (3) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    rd(ADDR_DATA, 32'h0);
    wb(1'b1, ADDR_SELECT, 32'h0);
    for (int i = 0; i < 9; i++) begin
      b = 8'($random(seed));
      mem[i % 8] = b;
      wb(1'b1, ADDR_DATA, {24'h0, b});
    end
    eng.peek(3'h3, b);
    chk({24'h0, b}, {24'h0, mem[3]});
    wb(1'b1, ADDR_SELECT, 32'h0);
    for (int i = 0; i < 8; i++) rd(ADDR_DATA, {24'h0, mem[i]});
    wb(1'b1, ADDR_SELECT, 32'hD);
    repeat (2) rd(ADDR_DATA, {24'h0, mem[5]});
    b = 8'($random(seed));
    eng.put(3'h2, b);
    wb(1'b1, ADDR_SELECT, 32'hA);
    rd(ADDR_DATA, {24'h0, b});
    for (int i = 0; i < 2; i++) begin
      b = i ? 8'($random(seed)) : 8'hF9;
      wb(1'b1, ADDR_LEN, {24'h0, b});
      rd(ADDR_LEN, {24'h0, clamp(b[7:4]), clamp(b[3:0])});
    end
    eng.evt(3'h7);
    wb(1'b1, ADDR_MASK, 32'h0);
    ci(1'b0);
    wb(1'b1, ADDR_MASK, 32'h4);
    ci(1'b1);
    wb(1'b1, ADDR_STATUS, 32'h7);
    ci(1'b0);
    wb(1'b1, ADDR_CTRL, 32'h1);
    b = 8'($random(seed));
    eng.put(3'h0, b);
    wb(1'b1, ADDR_SELECT, 32'h3);
    rd(ADDR_DATA, {24'h0, b});
    wb(1'b1, ADDR_SELECT, 32'h6);
    eng.evt(3'h5);
    rd(ADDR_STATUS, 32'h5);
    rd(ADDR_DATA, {24'h0, b});
    rd(ADDR_STATUS, 32'h0);
    eng.evt(3'h2);
    wb(1'b1, ADDR_DATA, {24'h0, ~b});
    rd(ADDR_STATUS, 32'h0);
    wb(1'b1, 4'hF, 32'hFF);
    chk({31'h0, e_seen}, 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
